// ### logic/mdt_pkg.sv
/*
 * Package for the multi-mode delay timer: mode codes, time base codes,
 * field positions of the packed time word and tick counts.
 * Assumes a 200 MHz clock feeding the timer.
 */
//
// Overview of operation
// R01 - Timing starts only on a start input transition.
// R02 - Extended pulse runs full preset despite start falling.
// R03 - Extended pulse status high exactly while running.
// R04 - Extended pulse start edge while running reloads preset.
// R05 - Pulse/on-delay reset edge clears count and base; pulse mode clears only while running and with no start edge.
// R06 - On-delay counts while start high; status after expiry.
// R07 - On-delay start fall halts timer, status low.
// R08 - On-delay reset level also clears idle timer.
// R09 - Retentive keeps counting after start falls.
// R10 - Retentive status high after expiry until reset.
// R11 - Retentive start edge before expiry restarts preset.
// R12 - Retentive reset edge clears regardless of start.
// R13 - Off-delay counts from start falling edge.
// R14 - Off-delay status is start or running.
// R15 - Off-delay start rise resets; waits next fall.
// R16 - Off-delay reset edge while counting resets timer.
// R17 - Remaining time shown in binary and BCD.
// R18 - Preset supplied within zero to 999.
// R19 - Count drops one per time base interval.
// R20 - Time base two bits at 12-13, four codes.
// R21 - Preset is three BCD digits, base above.
// R22 - Edges by registered compare; expired holds zero.
// R23 - BCD output carries base code; binary count only.
package mdt_pkg;

   typedef enum logic [1:0] {
      MDT_EXTENDED_PULSE_MODE     = 2'h0,
      MDT_ON_DELAY_MODE           = 2'h1,
      MDT_RETENTIVE_ON_DELAY_MODE = 2'h2,
      MDT_OFF_DELAY_MODE          = 2'h3
   } mdt_mode_t;

   // Timer states, Gray along idle -> running -> expired
   typedef enum logic [1:0] {
      MDT_IDLE    = 2'b00,
      MDT_RUNNING = 2'b01,
      MDT_EXPIRED = 2'b11
   } mdt_state_t;

   localparam int          MDT_WORD_W      = 16;
   localparam int          MDT_COUNT_W     = 10;
   localparam int          MDT_DIGITS      = 3;
   localparam int          MDT_BASE_LSB    = 12;
   localparam int          MDT_BASE_MSB    = 13;
   localparam logic [1:0]  MDT_BASE_RESET  = 2'h0;
   localparam logic [9:0]  MDT_COUNT_RESET = 10'h000;

   // Time base figures in microseconds and the clock rate
   localparam longint      MDT_CLK_HZ      = 200000000;
   localparam longint      MDT_BASE0_US    = 10000;
   localparam longint      MDT_BASE1_US    = 100000;
   localparam longint      MDT_BASE2_US    = 1000000;
   localparam longint      MDT_BASE3_US    = 10000000;
   localparam longint      MDT_BASE0_CYC   = MDT_BASE0_US * MDT_CLK_HZ / 1000000;
   localparam longint      MDT_BASE1_CYC   = MDT_BASE1_US * MDT_CLK_HZ / 1000000;
   localparam longint      MDT_BASE2_CYC   = MDT_BASE2_US * MDT_CLK_HZ / 1000000;
   localparam longint      MDT_BASE3_CYC   = MDT_BASE3_US * MDT_CLK_HZ / 1000000;
   localparam int          MDT_TICK_W      = 32;

endpackage : mdt_pkg

// ### logic/mdt_tick_gen.sv
/*
 * Time base tick generator: one-cycle tick at the selected interval.
 * Assumes the owner restarts it whenever a preset is loaded; each tick starts the next interval.
 */
`timescale 1ns/1ps
`default_nettype none
module mdt_tick_gen
   import mdt_pkg::*;
#(
   parameter logic [31:0] BASE0_CYCLES = 32'(MDT_BASE0_CYC),
   parameter logic [31:0] BASE1_CYCLES = 32'(MDT_BASE1_CYC),
   parameter logic [31:0] BASE2_CYCLES = 32'(MDT_BASE2_CYC),
   parameter logic [31:0] BASE3_CYCLES = 32'(MDT_BASE3_CYC)
)
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   input  wire logic       restart,
   input  wire logic       run,
   input  wire logic [1:0] base_code,
   output logic            tick
);
   import mdt_pkg::*;

   logic [MDT_TICK_W-1:0] count;
   logic [MDT_TICK_W-1:0] next_count;
   logic [MDT_TICK_W-1:0] limit;

   // Interval length for the selected base
   always_comb
   begin
      unique case (base_code)
         2'h0:    limit = BASE0_CYCLES;
         2'h1:    limit = BASE1_CYCLES;
         2'h2:    limit = BASE2_CYCLES;
         default: limit = BASE3_CYCLES;
      endcase
   end

   assign tick = run && !restart && (count >= limit - 32'h1);

   // Interval counter
   always_comb
   begin
      next_count = count;
      if (restart || !run || tick)
         next_count = '0;
      else
         next_count = count + 32'h1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count <= '0;
      else if (clk_en)
         count <= next_count;
   end

endmodule : mdt_tick_gen
`default_nettype wire

// ### logic/mdt_timer.sv
/*
 * Multi-mode delay timer: extended pulse, on-delay, retentive on-delay
 * and off-delay behaviours on one down counter.
 * Assumes start, reset and preset are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mdt_timer
   import mdt_pkg::*;
#(
   parameter logic [31:0] BASE0_CYCLES = 32'(MDT_BASE0_CYC),
   parameter logic [31:0] BASE1_CYCLES = 32'(MDT_BASE1_CYC),
   parameter logic [31:0] BASE2_CYCLES = 32'(MDT_BASE2_CYC),
   parameter logic [31:0] BASE3_CYCLES = 32'(MDT_BASE3_CYC)
)
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire mdt_pkg::mdt_mode_t mode,
   input  wire logic              start_in,
   input  wire logic              reset_in,
   input  wire logic [15:0]       preset_time,
   output logic                   status,
   output logic [15:0]            remaining_time_binary,
   output logic [15:0]            remaining_time_decimal
);
   import mdt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   mdt_state_t             state;
   mdt_state_t             next_state;
   logic [MDT_COUNT_W-1:0] count;
   logic [MDT_COUNT_W-1:0] next_count;
   logic [1:0]             base;
   logic [1:0]             next_base;
   logic                   start_q;
   logic                   reset_q;
   logic                   next_status;
   logic [15:0]            next_bin;
   logic [15:0]            next_dec;
   logic                   start_rise;
   logic                   start_fall;
   logic                   reset_rise;
   logic                   load;
   logic                   tick;
   logic [MDT_COUNT_W-1:0] preset_bin;
   logic [3:0]             dig [MDT_DIGITS];
   logic [3:0]             bcd [MDT_DIGITS];

   ////////////////////////////////////////////////////////////////////////
   // Edge detection

   // Compare inputs with their previous values
   assign start_rise = start_in && !start_q;   // [R01] [R22]
   assign start_fall = !start_in && start_q;   // [R13]
   assign reset_rise = reset_in && !reset_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         start_q <= 1'b0;
         reset_q <= 1'b0;
      end
      else if (clk_en)
      begin
         start_q <= start_in;
         reset_q <= reset_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Preset decode, BCD digits to binary

   // Three BCD digits in bits 0..11
   assign preset_bin = MDT_COUNT_W'(preset_time[11:8] * 7'd100    // [R21]
                     + preset_time[7:4] * 4'd10 + preset_time[3:0]);

   ////////////////////////////////////////////////////////////////////////
   // Time base ticks

   mdt_tick_gen #(
      .BASE0_CYCLES (BASE0_CYCLES),
      .BASE1_CYCLES (BASE1_CYCLES),
      .BASE2_CYCLES (BASE2_CYCLES),
      .BASE3_CYCLES (BASE3_CYCLES)
   ) i_mdt_tick_gen (
      .clk       (clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .restart   (load),
      .run       (state == MDT_RUNNING),
      .base_code (base),
      .tick      (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode control

   // Start, stop, reset and count decisions per mode
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_base  = base;
      load       = 1'b0;
      unique case (mode)
         MDT_EXTENDED_PULSE_MODE:
         begin
            if (start_rise)
               load = 1'b1;                                 // [R02] [R04]
            else if (reset_rise && state == MDT_RUNNING)
               next_state = MDT_IDLE;                       // [R05]
         end
         MDT_ON_DELAY_MODE:
         begin
            if (reset_in && !(state == MDT_RUNNING && !reset_rise))
               next_state = MDT_IDLE;                       // [R05] [R08]
            else if (reset_rise)
               next_state = MDT_IDLE;                       // [R05]
            else if (!start_in)
               next_state = MDT_IDLE;                       // [R07]
            else if (start_rise)
               load = 1'b1;                                 // [R06]
         end
         MDT_RETENTIVE_ON_DELAY_MODE:
         begin
            if (reset_rise)
               next_state = MDT_IDLE;                       // [R12]
            else if (start_rise && state != MDT_EXPIRED)
               load = 1'b1;                                 // [R09] [R11]
         end
         default:
         begin
            if (reset_rise && state == MDT_RUNNING)
               next_state = MDT_IDLE;                       // [R16]
            else if (start_rise)
               next_state = MDT_IDLE;                       // [R15]
            else if (start_fall)
               load = 1'b1;                                 // [R13]
         end
      endcase
      if (load)
      begin
         next_state = MDT_RUNNING;
         next_count = preset_bin;
         next_base  = preset_time[MDT_BASE_MSB:MDT_BASE_LSB];  // [R20]
      end
      else if (next_state == MDT_IDLE && state != MDT_IDLE)
      begin
         next_count = MDT_COUNT_RESET;                      // [R05]
         next_base  = MDT_BASE_RESET;
      end
      else if (state == MDT_RUNNING && (count == '0 || (tick && count == 10'h1)))
      begin
         next_state = MDT_EXPIRED;                          // [R22]
         next_count = '0;
      end
      else if (state == MDT_RUNNING && tick)
         next_count = count - 10'h1;                        // [R19]
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= MDT_IDLE;
         count <= MDT_COUNT_RESET;
         base  <= MDT_BASE_RESET;
      end
      else if (clk_en)
      begin
         state <= next_state;
         count <= next_count;
         base  <= next_base;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Binary count to BCD digits, one per generate step
   generate
      for (genvar d = 0; d < MDT_DIGITS; d++)
      begin : g_digit
         if (d == 0)
            assign dig[d] = 4'(next_count % 10'd10);
         else if (d == 1)
            assign dig[d] = 4'((next_count / 10'd10) % 10'd10);
         else
            assign dig[d] = 4'(next_count / 10'd100);
         assign bcd[d] = dig[d];
      end
   endgenerate

   // Status and remaining-time values
   always_comb
   begin
      unique case (mode)
         MDT_EXTENDED_PULSE_MODE:
            next_status = (next_state == MDT_RUNNING);              // [R03]
         MDT_ON_DELAY_MODE:
            next_status = (next_state == MDT_EXPIRED) && start_in;  // [R06] [R07]
         MDT_RETENTIVE_ON_DELAY_MODE:
            next_status = (next_state == MDT_EXPIRED);              // [R10]
         default:
            next_status = start_in || (next_state == MDT_RUNNING);  // [R14]
      endcase
      next_bin = {6'h0, next_count};                                // [R17] [R23]
      next_dec = {2'h0, next_base, bcd[2], bcd[1], bcd[0]};         // [R17] [R23]
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status                 <= 1'b0;
         remaining_time_binary  <= 16'h0000;
         remaining_time_decimal <= 16'h0000;
      end
      else if (clk_en)
      begin
         status                 <= next_status;
         remaining_time_binary  <= next_bin;
         remaining_time_decimal <= next_dec;
      end
   end

endmodule : mdt_timer
`default_nettype wire

// ### verification/mdt_timer_asserts.sv
/* Port checker for the delay timer.
   Bound into mdt_timer below; sees only the timer's ports. */
`timescale 1ns/1ps
`default_nettype none
module mdt_timer_asserts
   import mdt_pkg::*;
(
   input wire logic               clk,
   input wire logic               reset_n,
   input wire logic               clk_en,
   input wire mdt_pkg::mdt_mode_t mode,
   input wire logic               start_in,
   input wire logic               reset_in,
   input wire logic [15:0]        preset_time,
   input wire logic               status,
   input wire logic [15:0]        remaining_time_binary,
   input wire logic [15:0]        remaining_time_decimal
);
   import mdt_pkg::*;

   // Preset digits as a plain count
   logic [15:0] pre_bin;
   assign pre_bin = 16'(preset_time[11:8]) * 16'h64 + 16'(preset_time[7:4]) * 16'ha
      + 16'(preset_time[3:0]);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   AST_EXT_LOAD: assert property (clk_en && $past(clk_en) && $rose(start_in)
      && mode == MDT_EXTENDED_PULSE_MODE && !$rose(reset_in) && preset_time[11:0] != 12'h000
      |=> status && remaining_time_binary == $past(pre_bin)
      && remaining_time_decimal == {2'h0, $past(preset_time[13:0])}) else $error("load");
   AST_EXT_RESET: assert property (clk_en && $past(clk_en) && status && $rose(reset_in)
      && !$rose(start_in) && mode == MDT_EXTENDED_PULSE_MODE
      |=> !status && remaining_time_decimal == 16'h0000) else $error("ext reset");
   AST_ON_LEVEL: assert property (clk_en && mode == MDT_ON_DELAY_MODE && reset_in
      |=> !status && remaining_time_binary == 16'h0000) else $error("on reset level");
   AST_ON_START_LOW: assert property (clk_en && mode == MDT_ON_DELAY_MODE && !start_in
      |=> !status && remaining_time_binary == 16'h0000) else $error("on start low");
   AST_RET_HOLD: assert property (clk_en && mode == MDT_RETENTIVE_ON_DELAY_MODE
      && status && !reset_in |=> status) else $error("retentive hold");
   AST_OFF_START_HIGH: assert property (clk_en && mode == MDT_OFF_DELAY_MODE && start_in
      |=> status && remaining_time_binary == 16'h0000) else $error("off start high");
   AST_OFF_IDLE: assert property (clk_en && $past(clk_en) && $stable(mode)
      && mode == MDT_OFF_DELAY_MODE && !start_in && !$past(start_in) && !status
      |=> !status && remaining_time_binary == 16'h0000) else $error("off idle");
   AST_STEP: assert property (clk_en && $past(clk_en) && $past(reset_n) && $stable(start_in)
      && !reset_in && $stable(mode) |=> remaining_time_binary == $past(remaining_time_binary)
      || remaining_time_binary + 16'h0001 == $past(remaining_time_binary)) else $error("step");
endmodule : mdt_timer_asserts
bind mdt_timer mdt_timer_asserts i_mdt_timer_asserts (.clk, .reset_n, .clk_en, .mode, .start_in,
   .reset_in, .preset_time, .status, .remaining_time_binary, .remaining_time_decimal);
`default_nettype wire

// ### verification/mdt_ctrl_model.sv
/* Control logic model driving start, reset and preset.
   Assumes clk is the timer's clock; one request per call. */
`timescale 1ns/1ps
`default_nettype none
module mdt_ctrl_model
(
   input  wire logic   clk,
   output logic        start_in = 1'b0,
   output logic        reset_in = 1'b0,
   output logic [15:0] preset_time = 16'h0000
);
   // One request, launched just after an edge
   task automatic drive(input logic s, input logic r, input logic [15:0] p);
      @(posedge clk);
      #1;
      start_in = s;
      reset_in = r;
      preset_time = {2'h0, p[13:0]};
   endtask : drive
endmodule : mdt_ctrl_model
`default_nettype wire

// ### verification/tb_mdt_timer.sv
/* Testbench for the delay timer: one task per scenario.
   Assumes the control model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_mdt_timer;
   import mdt_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        start_in, reset_in, status;
   mdt_mode_t   mode = MDT_EXTENDED_PULSE_MODE;
   logic [15:0] preset_time, remaining_time_binary, remaining_time_decimal, st_bin;
   int          num_errors = 0;
   int          check_count = 0;
   // Status in the top bit, count below
   assign st_bin = {status, remaining_time_binary[14:0]};
   mdt_timer #(.BASE0_CYCLES(32'h4), .BASE1_CYCLES(32'h5), .BASE2_CYCLES(32'h6),
      .BASE3_CYCLES(32'h7)) i_mdt_timer (.clk, .reset_n, .clk_en, .mode, .start_in, .reset_in,
      .preset_time, .status, .remaining_time_binary, .remaining_time_decimal);
   mdt_ctrl_model i_mdt_ctrl_model (.clk, .start_in, .reset_in, .preset_time);
   // 200 MHz clock
   initial forever #2.5 clk = ~clk;
   ////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      num_errors += int'(got !== exp);
      if (got !== exp)
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
   endtask : chk
   task automatic go(input logic s, input logic r, input logic [15:0] p, input int n);
      i_mdt_ctrl_model.drive(s, r, p);
      if (n > 0) step(n);
   endtask : go
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////
   task automatic sc_ext;
      go(1, 0, 16'h0003, 1);
      chk(st_bin, 16'h8003);
      go(0, 0, 16'h0003, 4);
      chk(st_bin, 16'h8002);
      go(1, 0, 16'h0003, 1);
      chk(st_bin, 16'h8003);
      go(0, 0, 16'h0003, 10);
      chk(st_bin, 16'h8001);
      step(1);
      chk(st_bin, 16'h0000);
      go(1, 0, 16'h2005, 0);
      go(0, 1, 16'h2005, 1);
      chk(remaining_time_decimal, 16'h0000);
      go(0, 0, 16'h2005, 2);
   endtask : sc_ext
   task automatic sc_base;
      for (int b = 0; b < 4; b++)
      begin
         go(1, 0, {2'h0, 2'(b), 12'h001}, 1);
         chk(remaining_time_decimal, {2'h0, 2'(b), 12'h001});
         go(0, 0, 16'h0000, b + 2);
         chk(st_bin, 16'h8001);
         step(1);
         chk(st_bin, 16'h0000);
      end
   endtask : sc_base
   task automatic sc_on;
      mode = MDT_ON_DELAY_MODE;
      go(1, 1, 16'h0002, 1);
      chk(st_bin, 16'h0000);
      go(1, 0, 16'h0002, 1);
      chk(st_bin, 16'h0000);
      go(0, 0, 16'h0002, 0);
      go(1, 0, 16'h0002, 0);
      go(0, 0, 16'h0002, 1);
      chk(st_bin, 16'h0000);
      go(1, 0, 16'h0002, 8);
      chk(st_bin, 16'h0001);
      step(1);
      chk(st_bin, 16'h8000);
      go(0, 0, 16'h0002, 2);
   endtask : sc_on
   task automatic sc_ret;
      mode = MDT_RETENTIVE_ON_DELAY_MODE;
      go(1, 0, 16'h0002, 0);
      go(0, 0, 16'h0002, 0);
      go(1, 0, 16'h0002, 0);
      go(0, 0, 16'h0002, 7);
      chk(st_bin, 16'h0001);
      step(1);
      chk(st_bin, 16'h8000);
      go(1, 0, 16'h0002, 3);
      chk(st_bin, 16'h8000);
      go(1, 1, 16'h0002, 1);
      chk(st_bin, 16'h0000);
      go(0, 0, 16'h0002, 2);
   endtask : sc_ret
   task automatic sc_off;
      mode = MDT_OFF_DELAY_MODE;
      go(1, 0, 16'h0002, 1);
      chk(st_bin, 16'h8000);
      go(0, 0, 16'h0002, 0);
      go(1, 0, 16'h0002, 1);
      chk(st_bin, 16'h8000);
      go(0, 0, 16'h0002, 1);
      chk(st_bin, 16'h8002);
      go(0, 1, 16'h0002, 1);
      chk(st_bin, 16'h0000);
   endtask : sc_off
   // Frozen clock enable holds count and tick phase
   task automatic sc_hold;
      mode = MDT_EXTENDED_PULSE_MODE;
      go(1, 0, 16'h0100, 2);
      chk(st_bin, 16'h8064);
      chk(remaining_time_decimal, 16'h0100);
      clk_en = 1'b0;
      step(6);
      chk(st_bin, 16'h8064);
      clk_en = 1'b1;
      step(3);
      chk(st_bin, 16'h8063);
      chk(remaining_time_decimal, 16'h0099);
   endtask : sc_hold
   // Reset, then the scenarios
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      reset_n = 1'b1;
      sc_ext();
      sc_base();
      sc_on();
      sc_ret();
      sc_off();
      sc_hold();
      end_of_test();
   end
   // Cut a hang short, far past the scenarios' length
   initial
   begin
      repeat (1000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule : tb_mdt_timer
`default_nettype wire
